// ===== logic/art_regs.svh
`ifndef ART_REGS_SVH
`define ART_REGS_SVH
// Register indices; the byte address is four times the index.
`define ART_IDX_CTRL      8'h0d
`define ART_IDX_CNT_HIGH  8'h0e
`define ART_IDX_CNT_LOW   8'h0f
`define ART_IDX_RLD_HIGH  8'h10
`define ART_IDX_RLD_LOW   8'h11
`define ART_IDX_OUT_CTRL  8'h12
`define ART_IDX_CH_STAT   8'h13
`define ART_IDX_DUTY_HIGH 8'h17
`define ART_IDX_DUTY_LOW  8'h18
`define ART_IDX_PWR       8'h1f
// Control/status fields.
`define ART_CTRL_COMPARE_IRQ_ENABLE    0
`define ART_CTRL_WRAP_IRQ_ENABLE    1
`define ART_CTRL_OVF      2
`define ART_CTRL_CKLSB    3
`define ART_CTRL_CKMSB    4
`define ART_CH_CMPF       0
`define ART_CH_POL        1
`define ART_OUT_OE        0
`define ART_RESET_BYTE    8'h00
`define ART_RESET_WORD    12'h000
`define ART_CNT_TOP       12'hfff
// Timebase tick: 1 ms at 125 MHz.
`define ART_TB_PERIOD_US  1000
`define ART_TB_CYCLES     ((`ART_TB_PERIOD_US * 125) )
`define ART_SLOW_DIV      32
`endif

// ===== logic/art_pkg.sv
package art_pkg;
  typedef enum logic [1:0] {
    ART_CK_OFF  = 2'b00,
    ART_CK_TB   = 2'b01,
    ART_CK_CPU  = 2'b10,
    ART_CK_RSVD = 2'b11
  } art_clk_sel_type;
  typedef enum logic [1:0] {
    ART_PWR_RUN   = 2'b00,
    ART_PWR_WAIT  = 2'b01,
    ART_PWR_AHALT = 2'b11,
    ART_PWR_HALT  = 2'b10
  } art_pwr_type;
  typedef struct packed {
    logic       read;
    logic       write;
    logic [7:0] index;
    logic [7:0] data;
  } art_req_type;
endpackage

// ===== logic/art_timer.sv
// Contract
// - Counter starts at zero after reset; wraps reload it with reload value.
// - Period is 4096 minus reload value counter clocks.
// - Wrap loads reload, moves preloaded duty to active, drives pulse high.
// - Counter equal to active duty drives pulse low for rest of period.
// - Polarity one inverts pulse output, zero passes it.
// - Output enable drives pin push-pull with pulse; clear means compare mode.
// - Duty high byte write locks compare until duty low byte written.
// - In compare mode the written duty takes effect immediately.
// - Counter reaching compare value sets flag, irq if enabled.
// - Compare only happens when compare value is nonzero.
// - Every wrap copies duty into shadow; pwm uses shadow, compare uses duty.
// - Slow divides by 32; wait no effect; halt stops; active-halt conditional.
// - Both irqs wake wait; only wrap on timebase wakes active-halt.
// - Interrupts need enable bit and cleared processor mask; separate lines.
// - Clock select 00 off, 01 timebase, 10 cpu clock, 11 reserved.
// - Wrap flag set on FFF to reload; cleared by control register read.
// - Wrap flag reads high one more counter clock after clearing.
// - Counter runs whenever clocked; no high/low readback latch.
// - Channel status read clears the compare flag.
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "art_regs.svh"
module art_timer #(
  parameter int unsigned TB_CYCLES = `ART_TB_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        irq_mask_i,
  output logic             pulse_output_o,
  output logic             pulse_output_oe_n_o,
  output logic             wrap_irq_o,
  output logic             compare_irq_o,
  output logic             wake_o
);
  // Bus: one wait state, answer on the second edge of a request.
  logic        ack;
  logic [31:0] rdata;
  logic [7:0]  ctl_bits;
  logic        wrap_flag;
  logic        wrap_hold;
  logic [11:0] counter_value;
  logic [11:0] reload_value;
  logic [11:0] duty_value;
  logic [11:0] shadow;
  logic        cmp_locked;
  logic        channel_output_enable;
  logic        channel_polarity;
  logic        channel_compare_flag;
  logic        pulse;
  logic [1:0]  pwr;
  logic [16:0] tb_cnt;
  logic [4:0]  slow_cnt;
  logic        slow_mode;
  logic [11:0] last_cnt;
  logic        cnt_tick;

  wire [7:0] idx     = avs_address_i[9:2];
  wire       be0     = avs_byteenable_i[0];
  wire       req     = (avs_read_i | avs_write_i) & ~ack;
  wire       wr      = avs_write_i & ack & be0;
  wire       rd      = avs_read_i & ack;
  wire [7:0] wd      = avs_writedata_i[7:0];
  wire art_pkg::art_clk_sel_type clk_sel =
    art_pkg::art_clk_sel_type'(ctl_bits[`ART_CTRL_CKMSB:`ART_CTRL_CKLSB]);
  wire art_pkg::art_pwr_type pwr_mode = art_pkg::art_pwr_type'(pwr);
  wire       wrap_irq_enable    = ctl_bits[`ART_CTRL_WRAP_IRQ_ENABLE];
  wire       compare_irq_enable = ctl_bits[`ART_CTRL_COMPARE_IRQ_ENABLE];

  // Timebase tick and CPU-clock source; slow mode divides either by 32.
  wire tb_tick  = (tb_cnt == 17'(TB_CYCLES - 1));
  wire src_tick = (clk_sel == art_pkg::ART_CK_TB)  ? tb_tick :
                  (clk_sel == art_pkg::ART_CK_CPU) ? 1'b1 : 1'b0;
  wire halted   = (pwr_mode == art_pkg::ART_PWR_HALT) |
                  ((pwr_mode == art_pkg::ART_PWR_AHALT) &
                   ~((clk_sel == art_pkg::ART_CK_TB) &
                     wrap_irq_enable));
  wire next_tick = src_tick & ~halted &
                   (~slow_mode || slow_cnt == 5'(`ART_SLOW_DIV - 1));

  wire at_top    = (counter_value == `ART_CNT_TOP);
  wire wrap_ev   = next_tick & at_top;
  wire [11:0] next_counter =
    at_top ? reload_value : counter_value + 12'h001;
  wire [11:0] cmp_ref = channel_output_enable ? shadow : duty_value;
  wire cmp_hit   = next_tick & ~at_top & ~cmp_locked &
                   (cmp_ref != `ART_RESET_WORD) &
                   (next_counter == cmp_ref);

  always_comb begin
    unique case (idx)
      `ART_IDX_CTRL:      rdata = {24'h0, 3'h0, ctl_bits[4:3], wrap_flag,
                                   ctl_bits[1:0]};
      `ART_IDX_CNT_HIGH:  rdata = {28'h0, counter_value[11:8]};
      `ART_IDX_CNT_LOW:   rdata = {24'h0, counter_value[7:0]};
      `ART_IDX_RLD_HIGH:  rdata = {28'h0, reload_value[11:8]};
      `ART_IDX_RLD_LOW:   rdata = {24'h0, reload_value[7:0]};
      `ART_IDX_OUT_CTRL:  rdata = {31'h0, channel_output_enable};
      `ART_IDX_CH_STAT:   rdata = {30'h0, channel_polarity,
                                   channel_compare_flag};
      `ART_IDX_DUTY_HIGH: rdata = {28'h0, duty_value[11:8]};
      `ART_IDX_DUTY_LOW:  rdata = {24'h0, duty_value[7:0]};
      `ART_IDX_PWR:       rdata = {30'h0, pwr};
      default:            rdata = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack               <= 1'b0;
      avs_readdata_o    <= 32'h0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      ack               <= req;
      avs_waitrequest_o <= ~req;
      if (req && avs_read_i)
        avs_readdata_o <= rdata;
    end
  end

  // Timebase divider and slow prescaler.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tb_cnt   <= 17'h0;
      slow_cnt <= 5'h0;
    end else begin
      tb_cnt <= tb_tick ? 17'h0 : tb_cnt + 17'h1;
      if (src_tick && !halted)
        slow_cnt <= slow_cnt + 5'h1;
    end
  end

  // Software registers.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_bits              <= `ART_RESET_BYTE;
      reload_value          <= `ART_RESET_WORD;
      duty_value            <= `ART_RESET_WORD;
      channel_output_enable <= 1'b0;
      channel_polarity      <= 1'b0;
      pwr                   <= 2'h0;
      slow_mode             <= 1'b0;
      cmp_locked            <= 1'b0;
    end else if (wr) begin
      unique case (idx)
        `ART_IDX_CTRL: begin
          ctl_bits[4:3] <= wd[4:3];
          ctl_bits[1:0] <= wd[1:0];
        end
        `ART_IDX_RLD_HIGH:  reload_value[11:8] <= wd[3:0];
        `ART_IDX_RLD_LOW:   reload_value[7:0]  <= wd;
        `ART_IDX_OUT_CTRL:  channel_output_enable <= wd[`ART_OUT_OE];
        `ART_IDX_CH_STAT:   channel_polarity <= wd[`ART_CH_POL];
        `ART_IDX_DUTY_HIGH: begin
          duty_value[11:8] <= wd[3:0];
          cmp_locked       <= 1'b1;
        end
        `ART_IDX_DUTY_LOW: begin
          duty_value[7:0] <= wd;
          cmp_locked      <= 1'b0;
        end
        `ART_IDX_PWR: begin
          pwr       <= wd[1:0];
          slow_mode <= wd[2];
        end
        default: ;
      endcase
    end
  end

  // Counter, shadow, pulse and flags.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      counter_value        <= `ART_RESET_WORD;
      shadow               <= `ART_RESET_WORD;
      pulse                <= 1'b0;
      wrap_flag            <= 1'b0;
      wrap_hold            <= 1'b0;
      channel_compare_flag <= 1'b0;
    end else begin
      if (next_tick) begin
        counter_value <= next_counter;
        wrap_hold     <= 1'b0;
      end
      if (wrap_ev) begin
        shadow <= duty_value;
        pulse  <= 1'b1;
      end else if (cmp_hit && channel_output_enable) begin
        pulse <= 1'b0;
      end
      // Set wins over a clearing read.
      if (wrap_ev)
        wrap_flag <= 1'b1;
      else if (rd && idx == `ART_IDX_CTRL && wrap_flag) begin
        wrap_hold <= 1'b1;
      end else if (wrap_hold && next_tick)
        wrap_flag <= 1'b0;
      if (cmp_hit)
        channel_compare_flag <= 1'b1;
      else if (rd && idx == `ART_IDX_CH_STAT)
        channel_compare_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_output_o      <= 1'b0;
      pulse_output_oe_n_o <= 1'b1;
      wrap_irq_o          <= 1'b0;
      compare_irq_o       <= 1'b0;
      wake_o              <= 1'b0;
    end else begin
      pulse_output_o      <= pulse ^ channel_polarity;
      pulse_output_oe_n_o <= ~channel_output_enable;
      wrap_irq_o    <= wrap_flag & wrap_irq_enable & ~irq_mask_i;
      compare_irq_o <= channel_compare_flag & compare_irq_enable &
                       ~irq_mask_i;
      wake_o <= ((pwr_mode == art_pkg::ART_PWR_WAIT) &
                 ((wrap_flag & wrap_irq_enable) |
                  (channel_compare_flag & compare_irq_enable))) |
                ((pwr_mode == art_pkg::ART_PWR_AHALT) &
                 (clk_sel == art_pkg::ART_CK_TB) &
                 wrap_flag & wrap_irq_enable);
    end
  end
endmodule
`default_nettype wire

// ===== bench/art_timer_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "art_regs.svh"
module art_timer_checker (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic [9:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        irq_mask_i,
  input wire logic        pulse_output_oe_n_o,
  input wire logic        wrap_irq_o,
  input wire logic        compare_irq_o,
  input wire logic        wake_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Shadow copies are taken at the accepting edge, as the block takes them.
  wire        [7:0] idx = avs_address_i[9:2];
  wire              wr  = avs_write_i & ~avs_waitrequest_o &
                          avs_byteenable_i[0];
  logic       [4:0] ctl;
  logic       [1:0] pwr;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl <= 5'h00;
      pwr <= 2'h0;
    end else if (wr && idx == `ART_IDX_CTRL) begin
      ctl <= avs_writedata_i[4:0];
    end else if (wr && idx == `ART_IDX_PWR) begin
      pwr <= avs_writedata_i[1:0];
    end
  end
  a_bus_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("late answer");
  a_answer_short: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("long answer");
  a_irq_masked: assert property (
    $past(irq_mask_i) |-> !wrap_irq_o && !compare_irq_o)
    else $error("irq while masked");
  a_wrap_irq_en: assert property (wrap_irq_o |-> $past(ctl[1]))
    else $error("wrap irq not enabled");
  a_cmp_irq_en: assert property (compare_irq_o |-> $past(ctl[0]))
    else $error("compare irq not enabled");
  a_oe_tracks: assert property (
    wr && idx == `ART_IDX_OUT_CTRL |->
    ##3 pulse_output_oe_n_o == !$past(avs_writedata_i[0], 3))
    else $error("pin enable wrong");
  a_halt_no_wake: assert property (wake_o |-> $past(pwr) != 2'b10)
    else $error("wake in halt");
  a_ahalt_wake: assert property (
    wake_o && $past(pwr) == 2'b11 |->
    $past(ctl[4:3]) == 2'b01 && $past(ctl[1]))
    else $error("bad active-halt wake");
endmodule
`default_nettype wire

// ===== bench/art_timer_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module art_timer_test;
  logic        ref_clk_i        = 1'b0;
  logic        rst_i            = 1'b1;
  logic [9:0]  avs_address_i    = 10'h000;
  logic        avs_read_i       = 1'b0;
  logic        avs_write_i      = 1'b0;
  logic [31:0] avs_writedata_i  = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic        irq_mask_i       = 1'b0;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o, pulse_output_o, pulse_output_oe_n_o;
  wire         wrap_irq_o, compare_irq_o, wake_o;
  logic [7:0]  rd, c;
  logic [7:0]  ix [10] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13,
                           8'h17, 8'h18, 8'h14};
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  int          h, l;
  art_timer #(.TB_CYCLES(4)) dut (.ref_clk_i, .rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .irq_mask_i, .pulse_output_o,
    .pulse_output_oe_n_o, .wrap_irq_o, .compare_irq_o, .wake_o);
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results;
    end
  end
  task results;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // An edge passes first, so a release and a new request never share a step.
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge ref_clk_i);
    avs_address_i <= {i, 2'b00};
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= w;
    avs_read_i <= ~w;
    do @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask
  task rg(input logic [7:0] i);
    bus(1'b0, i, 8'h00);
  endtask
  task automatic meas(input logic v);
    wait (pulse_output_o === ~v);
    wait (pulse_output_o === v);
    @(negedge ref_clk_i);
    h = 0;
    l = 0;
    while (pulse_output_o === v) begin
      @(negedge ref_clk_i);
      h++;
    end
    while (pulse_output_o === ~v) begin
      @(negedge ref_clk_i);
      l++;
    end
  endtask
  task t_reset;
    wr(8'h14, 8'hff);
    foreach (ix[k]) begin
      rg(ix[k]);
      `CHK("reset value", 8'h00, rd);
    end
    `CHK("pin released", 1'b1, pulse_output_oe_n_o);
    $display("reset test done");
  endtask
  task t_pwm;
    wr(8'h10, 8'h0f);
    wr(8'h11, 8'hf0);
    wr(8'h17, 8'h0f);
    wr(8'h18, 8'hf8);
    wr(8'h12, 8'h01);
    wr(8'h0d, 8'h10);
    meas(1'b1);
    `CHK("high time", 32'h8, h);
    `CHK("period", 32'h10, h + l);
    `CHK("pin driven", 1'b0, pulse_output_oe_n_o);
    rg(8'h0f);
    rg(8'h0e);
    `CHK("count high", 8'h0f, rd);
    wr(8'h13, 8'h02);
    meas(1'b0);
    `CHK("inverted time", 32'h8, h);
    wr(8'h13, 8'h00);
    $display("pwm test done");
  endtask
  task t_ovf;
    wr(8'h0d, 8'h12);
    wait (pulse_output_o === 1'b0);
    wait (pulse_output_o === 1'b1);
    repeat (3) @(negedge ref_clk_i);
    `CHK("wrap irq", 1'b1, wrap_irq_o);
    rg(8'h0d);
    `CHK("wrap flag", 1'b1, rd[2]);
    repeat (4) @(negedge ref_clk_i);
    rg(8'h0d);
    `CHK("flag cleared", 1'b0, rd[2]);
    @(posedge ref_clk_i);
    irq_mask_i <= 1'b1;
    wait (pulse_output_o === 1'b0);
    wait (pulse_output_o === 1'b1);
    repeat (3) @(negedge ref_clk_i);
    `CHK("masked irq", 1'b0, wrap_irq_o);
    @(posedge ref_clk_i);
    irq_mask_i <= 1'b0;
    $display("wrap test done");
  endtask
  task t_cmp;
    wr(8'h12, 8'h00);
    wr(8'h0d, 8'h11);
    wr(8'h17, 8'h0f);
    rg(8'h13);
    repeat (40) @(negedge ref_clk_i);
    rg(8'h13);
    `CHK("locked", 1'b0, rd[0]);
    wr(8'h18, 8'hf8);
    repeat (20) @(negedge ref_clk_i);
    `CHK("compare irq", 1'b1, compare_irq_o);
    wr(8'h0d, 8'h19);
    rg(8'h13);
    `CHK("compare flag", 1'b1, rd[0]);
    rg(8'h13);
    `CHK("flag cleared", 1'b0, rd[0]);
    rg(8'h0f);
    c = rd;
    repeat (10) @(negedge ref_clk_i);
    rg(8'h0f);
    `CHK("reserved clock", c, rd);
    $display("compare test done");
  endtask
  task t_pwr;
    wr(8'h0d, 8'h0b);
    wr(8'h1f, 8'h02);
    rg(8'h0f);
    c = rd;
    repeat (40) @(negedge ref_clk_i);
    rg(8'h0f);
    `CHK("halted count", c, rd);
    `CHK("halt wake", 1'b0, wake_o);
    wr(8'h1f, 8'h03);
    // A stale wrap flag would wake at once, so it is cleared first.
    rg(8'h0d);
    repeat (200) @(negedge ref_clk_i);
    `CHK("active-halt wake", 1'b1, wake_o);
    wr(8'h1f, 8'h00);
    $display("power test done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_pwm;
    t_ovf;
    t_cmp;
    t_pwr;
    results;
  end
endmodule
bind art_timer art_timer_checker chk (.ref_clk_i, .rst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_waitrequest_o, .irq_mask_i, .pulse_output_oe_n_o, .wrap_irq_o,
  .compare_irq_o, .wake_o);
`default_nettype wire
